// ---- rtl/dimming_control.v ----
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "dimming_defs.vh"
module dimming_control #(
  parameter SINKS = 8,
  parameter DUTY_BITS = 8
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  input wire ce,
  // Switching tick and frequency select
  input wire sw_tick,
  input wire freq_set_pin,
  // Host dimming inputs
  input wire enable_in,
  input wire onoff_in,
  input wire analog_dim_input,
  // Sink feedback
  input wire [SINKS-1:0] sink_at_reg,
  input wire [SINKS-1:0] sink_open,
  input wire overvoltage_protect,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // Outputs to analog core
  output reg [SINKS-1:0] sink_enable,
  output reg [SINKS-1:0] sink_in_loop,
  output reg [4:0] current_level,
  output reg [DUTY_BITS-1:0] analog_duty,
  output reg analog_mode,
  output reg boost_enable,
  output reg boost_limit_high,
  output reg soft_start
);

  localparam ST_OFF = 2'h0;
  localparam ST_HOLD = 2'h1;
  localparam ST_SOFT = 2'h2;
  localparam ST_RUN = 2'h3;

  // ==========================================================
  // Input synchronisation
  wire [2:0] pins_sync;
  wire [SINKS+SINKS:0] fb_sync;
  input_sync #(.WIDTH(3)) pin_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in({analog_dim_input, onoff_in, enable_in}),
    .sync_out(pins_sync)
  );
  input_sync #(.WIDTH(SINKS+SINKS+1)) fb_sync_i (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in({overvoltage_protect, sink_open, sink_at_reg}),
    .sync_out(fb_sync)
  );
  wire tick_sync;
  wire fsel_sync;
  input_sync #(.WIDTH(2)) misc_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in({freq_set_pin, sw_tick}),
    .sync_out({fsel_sync, tick_sync})
  );

  wire en_s = pins_sync[0];
  wire pw_s = pins_sync[1];
  wire ap_s = pins_sync[2];
  wire [SINKS-1:0] at_reg_s = fb_sync[SINKS-1:0];
  wire [SINKS-1:0] open_s = fb_sync[2*SINKS-1:SINKS];
  wire overvolt_s = fb_sync[2*SINKS];

  reg en_d;
  reg pw_d;
  reg ap_d;
  reg tick_d;

  // ==========================================================
  // Switching period prescaler
  reg [1:0] pre;
  wire tick_edge = tick_sync && !tick_d;
  wire period = tick_edge && (!fsel_sync || pre == `SW_DIV_RATIO);

  // ==========================================================
  // Registers
  reg [7:0] ctrl;
  reg [1:0] mode;
  reg [1:0] state;
  reg [3:0] pulse_count;
  reg [8:0] hold_count;
  reg [8:0] low_count;
  reg [3:0] applied_count;
  reg [SINKS-1:0] dropped;
  wire [DUTY_BITS-1:0] duty_w;

  duty_meter #(.WINDOW_BITS(DUTY_BITS)) duty_i (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .level_in(ap_s),
    .duty(duty_w)
  );

  // Period counts depend on divider setting
  wire [8:0] hold_limit = fsel_sync ? `HOLD_DIV : `HOLD_UNDIV;
  wire [8:0] eos_limit = fsel_sync ? `EOS_HOLD_DIV : `EOS_HOLD_UNDIV;
  wire all_low = !en_s && !pw_s && !ap_s;
  wire [SINKS-1:0] active = ctrl[SINKS-1:0];

  function [4:0] level_of;
    input [3:0] count;
    begin
      level_of = (count == 4'h0) ? `LEVEL_FULL : (5'h10 - {1'b0, count});
    end
  endfunction

  // Sinks and boost are live in soft start and run alike
  function running;
    input [1:0] st;
    begin
      running = (st == ST_SOFT) || (st == ST_RUN);
    end
  endfunction

  // ==========================================================
  // Mode and sequence control
  always @(posedge clk) begin
    if (reset) begin
      en_d <= 1'b0;
      pw_d <= 1'b0;
      ap_d <= 1'b0;
      tick_d <= 1'b0;
      pre <= 2'h0;
      ctrl <= `CTRL_RESET;
      mode <= `MODE_OFF;
      state <= ST_OFF;
      pulse_count <= 4'h0;
      applied_count <= 4'h0;
      hold_count <= 9'h000;
      low_count <= 9'h000;
      dropped <= {SINKS{1'b0}};
    end else if (ce) begin
      en_d <= en_s;
      pw_d <= pw_s;
      ap_d <= ap_s;
      tick_d <= tick_sync;
      if (tick_edge) begin
        pre <= pre + 2'h1;
      end
      if (reg_write && reg_addr == `REG_CTRL) begin
        ctrl <= reg_wdata;
      end
      // Edge restarts hold counter; else count periods up to saturation
      if (en_s != en_d || ap_s != ap_d) begin
        hold_count <= 9'h000;
      end else if (period && hold_count != 9'h1ff) begin
        hold_count <= hold_count + 9'h001;
      end
      if (!all_low) begin
        low_count <= 9'h000;
      end else if (period && low_count != 9'h1ff) begin
        low_count <= low_count + 9'h001;
      end
      // Open string leaves the loop on overvoltage; rejoins when an overvoltage sample sees it closed, or in the off state
      if (state == ST_OFF) begin
        dropped <= {SINKS{1'b0}};
      end else if (overvolt_s) begin
        dropped <= (dropped | (open_s & active)) & ~(dropped & ~open_s);
      end
      case (state)
        ST_OFF: begin
          // No count survives a shutdown into the next start
          pulse_count <= 4'h0;
          applied_count <= 4'h0;
          if (en_s && !en_d && pw_s && !ap_s) begin
            mode <= `MODE_COUNT;
            state <= ST_HOLD;
          end else if (pw_s && !pw_d && !en_s && !ap_s) begin
            mode <= `MODE_ONOFF;
            state <= ST_SOFT;
          end else if (ap_s && !ap_d && !en_s && !pw_s) begin
            mode <= `MODE_ANALOG;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Pulses ignored until references settle
          if (hold_count >= hold_limit) begin
            state <= ST_SOFT;
          end
        end
        ST_SOFT: begin
          if ((at_reg_s & active) == active) begin
            state <= ST_RUN;
          end
        end
        default: begin
          if (mode == `MODE_COUNT) begin
            if (en_s && !en_d) begin
              pulse_count <= pulse_count + 4'h1;
            end else if (en_s && period && hold_count == eos_limit) begin
              // Equality fires once per long high, so a count is applied once
              applied_count <= pulse_count;
              pulse_count <= 4'h0;
            end
          end
        end
      endcase
      // Shutdown paths override; on/off mode stops at once
      if (state != ST_OFF) begin
        if (mode == `MODE_ONOFF && !pw_s) begin
          state <= ST_OFF;
          mode <= `MODE_OFF;
        end else if (mode != `MODE_ONOFF && low_count > hold_limit) begin
          // Normal operation through the whole delay; strictly greater
          state <= ST_OFF;
          mode <= `MODE_OFF;
        end
      end
    end
  end

  // ==========================================================
  // Outputs, all registered
  always @(posedge clk) begin
    if (reset) begin
      sink_enable <= {SINKS{1'b0}};
      sink_in_loop <= {SINKS{1'b0}};
      current_level <= 5'h00;
      analog_duty <= {DUTY_BITS{1'b0}};
      analog_mode <= 1'b0;
      boost_enable <= 1'b0;
      boost_limit_high <= 1'b0;
      soft_start <= 1'b0;
      reg_rdata <= 8'h00;
    end else if (ce) begin
      sink_enable <= running(state) ? active : {SINKS{1'b0}};
      // Only live, enabled sinks may steer the boost loop
      if (running(state)) begin
        sink_in_loop <= active & ~dropped;
      end else begin
        sink_in_loop <= {SINKS{1'b0}};
      end
      soft_start <= (state == ST_SOFT);
      boost_enable <= running(state);
      boost_limit_high <= (state == ST_RUN);
      analog_mode <= (mode == `MODE_ANALOG);
      analog_duty <= (mode == `MODE_ANALOG) ? duty_w : {DUTY_BITS{1'b1}};
      if (state == ST_SOFT) begin
        current_level <= `LEVEL_SOFT;
      end else if (state == ST_RUN) begin
        current_level <= (mode == `MODE_COUNT) ? level_of(applied_count) : `LEVEL_FULL;
      end else begin
        current_level <= 5'h00;
      end
      if (reg_read) begin
        case (reg_addr)
          `REG_CTRL: reg_rdata <= ctrl;
          `REG_STATUS: reg_rdata <= {2'h0, fsel_sync, ap_s, mode, state};
          `REG_LEVEL: reg_rdata <= {pulse_count, applied_count};
          `REG_DUTY: reg_rdata <= duty_w[DUTY_BITS-1:DUTY_BITS-8];
          `REG_OPEN: reg_rdata <= dropped[7:0];
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule // dimming_control
`default_nettype wire

// ---- rtl/dimming_defs.vh ----
`ifndef DIMMING_DEFS_VH
`define DIMMING_DEFS_VH
// Hold and shutdown periods, in switching periods
`define HOLD_UNDIV 9'h100
`define HOLD_DIV 9'h040
`define EOS_HOLD_DIV 9'h100
`define EOS_HOLD_UNDIV 9'h040
// Prescaler terminal count when frequency select is high; one tick in four makes a period
`define SW_DIV_RATIO 2'h3
// Level encoding
`define LEVEL_FULL 5'h10
`define LEVEL_SOFT 5'h01
// Mode encoding
`define MODE_OFF 2'h0
`define MODE_COUNT 2'h1
`define MODE_ONOFF 2'h2
`define MODE_ANALOG 2'h3
// Register map
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_LEVEL 4'h2
`define REG_DUTY 4'h3
`define REG_OPEN 4'h4
`define CTRL_RESET 8'hff
`endif

// ---- rtl/duty_meter.v ----
`timescale 1ns/100ps
`default_nettype none
// Measures high time over a fixed window of clock cycles
module duty_meter #(
  parameter WINDOW_BITS = 8
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire level_in,
  output reg [WINDOW_BITS-1:0] duty
);

  reg [WINDOW_BITS-1:0] window_count;
  reg [WINDOW_BITS-1:0] high_count;

  // Full window of highs saturates rather than wrapping to zero
  always @(posedge clk) begin
    if (reset) begin
      window_count <= {WINDOW_BITS{1'b0}};
      high_count <= {WINDOW_BITS{1'b0}};
      duty <= {WINDOW_BITS{1'b0}};
    end else if (ce) begin
      window_count <= window_count + 1'b1;
      if (&window_count) begin
        duty <= (level_in && (&high_count)) ? high_count : high_count + {{(WINDOW_BITS-1){1'b0}}, level_in};
        high_count <= {WINDOW_BITS{1'b0}};
      end else if (level_in && !(&high_count)) begin
        high_count <= high_count + 1'b1;
      end
    end
  end

endmodule // duty_meter
`default_nettype wire

// ---- rtl/input_sync.v ----
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a bus of asynchronous levels
module input_sync #(
  parameter WIDTH = 3
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk) begin
    if (reset) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (ce) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // input_sync
`default_nettype wire

// ---- verif/dimming_control_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module dimming_control_properties #(
  parameter SINKS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host lines and register port
  input wire logic enable_in,
  input wire logic onoff_in,
  input wire logic analog_dim_input,
  input wire logic [3:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Outputs to analog core
  input wire logic [SINKS-1:0] sink_enable,
  input wire logic [SINKS-1:0] sink_in_loop,
  input wire logic [4:0] current_level,
  input wire logic boost_enable,
  input wire logic boost_limit_high,
  input wire logic soft_start
);
  // ==========
  // Properties
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  soft_limit_a: assert property (soft_start |-> !boost_limit_high) else $error("limit high in soft start");
  soft_level_a: assert property (soft_start |-> current_level == 5'h01) else $error("soft level wrong");
  level_range_a: assert property (current_level <= 5'h10) else $error("level above full");
  loop_subset_a: assert property ((sink_in_loop & ~sink_enable) == '0) else $error("disabled sink in loop");
  rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data outside slot");
  unmapped_rd_a: assert property ($past(reg_read) && $past(reg_addr) > 4'h4 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  shut_hold_a: assert property (($fell(enable_in) || $fell(analog_dim_input)) && boost_enable && !onoff_in
    |-> boost_enable[*8]) else $error("early shutdown");
  soft_entry_a: assert property ($rose(boost_enable) |-> !boost_limit_high[*2]) else $error("start skipped soft start");
  onoff_stop_a: assert property ($fell(onoff_in) && !enable_in && !analog_dim_input && boost_enable
    |-> ##[1:8] !boost_enable) else $error("late on/off shutdown");
endmodule // dimming_control_properties
bind dimming_control dimming_control_properties #(.SINKS(SINKS)) dimming_control_properties_i (
  .clk(clk), .reset(reset), .enable_in(enable_in), .onoff_in(onoff_in), .analog_dim_input(analog_dim_input),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .sink_enable(sink_enable),
  .sink_in_loop(sink_in_loop), .current_level(current_level), .boost_enable(boost_enable),
  .boost_limit_high(boost_limit_high), .soft_start(soft_start)
);
`default_nettype wire

// ---- verif/dimming_control_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module dimming_control_tb_top;
  logic clk = 1'b0, reset = 1'b1, sw_tick = 1'b0, freq_set_pin = 1'b0, overvolt = 1'b0;
  logic [7:0] sink_at_reg = 8'h00, sink_open = 8'h00, reg_wdata = 8'h00, obs;
  logic [2:0] tick_cnt = 3'h0;
  logic [3:0] reg_addr = 4'h0;
  logic reg_write = 1'b0, reg_read = 1'b0, rd_d = 1'b0, look = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] exp_q[$];
  wire logic enable_in, onoff_in, analog_dim_input, analog_mode, boost_enable, boost_limit_high, soft_start;
  wire logic [7:0] reg_rdata, sink_enable, analog_duty, sink_in_loop;
  wire logic [4:0] current_level;
  int error_cnt = 0, compares = 0, cycles = 0, n, hi;
  always #2 clk = ~clk;
  // Switching oscillator, eight clocks a period, moved only on clock edges
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 3'h1;
    sw_tick <= tick_cnt[2];
  end
  host_model host_model_i (.clk(clk), .enable_in(enable_in), .onoff_in(onoff_in), .analog_dim_input(analog_dim_input));
  dimming_control dimming_control_i (
    .clk(clk), .reset(reset), .ce(1'b1), .sw_tick(sw_tick), .freq_set_pin(freq_set_pin), .enable_in(enable_in),
    .onoff_in(onoff_in), .analog_dim_input(analog_dim_input), .sink_at_reg(sink_at_reg), .sink_open(sink_open),
    .overvoltage_protect(overvolt), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .sink_enable(sink_enable), .sink_in_loop(sink_in_loop),
    .current_level(current_level), .analog_duty(analog_duty), .analog_mode(analog_mode),
    .boost_enable(boost_enable), .boost_limit_high(boost_limit_high), .soft_start(soft_start)
  );
  // ==========
  // Result watcher
  always @(posedge clk) begin
    rd_d <= reg_read;
    cycles <= cycles + 1;
    if (rd_d || look) begin
      case (sel)
        3'h1: obs = {3'h0, current_level};
        3'h2: obs = {7'h00, boost_enable};
        3'h3: obs = {7'h00, boost_limit_high};
        3'h4: obs = sink_enable;
        3'h5: obs = {7'h00, analog_mode};
        3'h6: obs = 8'(({1'b0, analog_duty} + 9'h008) >> 4);
        3'h7: obs = {7'h00, soft_start};
        default: obs = rd_d ? reg_rdata : sink_in_loop;
      endcase
      compares++;
      if (obs !== exp_q.pop_front()) begin
        error_cnt++;
        $display("[FAIL] %0t check %0d got %h", $time, sel, obs);
      end
    end
    if (cycles == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========
  // Driver tasks
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic chk(input logic [2:0] s, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    sel <= s;
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    sel <= 3'h0;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    void'($urandom(56151));
    wt(6);
    reset <= 1'b0;
    rd(4'h0, 8'hff);
    rd(4'hf, 8'h00);
    wr(4'h0, 8'h0f);
    wr(4'h9, 8'h55);
    rd(4'h0, 8'h0f);
    // On/off period scaled far below the recommended band to keep runs short
    host_model_i.set_lines(1'b0, 1'b1, 1'b0);
    wt(40);
    chk(3'h2, 8'h01);
    // One enabled sink short of regulation keeps soft start
    sink_at_reg <= 8'h07;
    wt(20);
    chk(3'h7, 8'h01);
    chk(3'h1, 8'h01);
    chk(3'h3, 8'h00);
    sink_at_reg <= 8'h0f;
    wt(20);
    chk(3'h1, 8'h10);
    chk(3'h3, 8'h01);
    chk(3'h4, 8'h0f);
    // Open string seen during overvoltage leaves the loop but stays enabled
    sink_open <= 8'h04;
    overvolt <= 1'b1;
    wt(6);
    overvolt <= 1'b0;
    wt(4);
    chk(3'h0, 8'h0b);
    rd(4'h4, 8'h04);
    chk(3'h4, 8'h0f);
    sink_open <= 8'h00;
    overvolt <= 1'b1;
    wt(6);
    overvolt <= 1'b0;
    wt(4);
    chk(3'h0, 8'h0f);
    host_model_i.set_lines(1'b0, 1'b0, 1'b0);
    wt(12);
    chk(3'h2, 8'h00);
    sink_at_reg <= 8'h00;
    host_model_i.set_lines(1'b1, 1'b1, 1'b0);
    wt(2300);
    sink_at_reg <= 8'h0f;
    wt(20);
    chk(3'h1, 8'h10);
    n = $urandom_range(15, 1);
    host_model_i.pulses(n);
    wt(1000);
    chk(3'h1, 8'(16 - n));
    rd(4'h2, 8'(n));
    host_model_i.pulses(17);
    wt(1000);
    chk(3'h1, 8'h0f);
    freq_set_pin <= 1'b1;
    host_model_i.pulses(4);
    wt(1500);
    chk(3'h1, 8'h0f);
    wt(7000);
    chk(3'h1, 8'h0c);
    rd(4'h1, 8'h27);
    freq_set_pin <= 1'b0;
    host_model_i.set_lines(1'b1, 1'b0, 1'b0);
    host_model_i.set_lines(1'b0, 1'b0, 1'b0);
    wt(1000);
    chk(3'h2, 8'h01);
    wt(1500);
    chk(3'h2, 8'h00);
    chk(3'h4, 8'h00);
    chk(3'h0, 8'h00);
    sink_at_reg <= 8'h00;
    host_model_i.set_lines(1'b0, 1'b0, 1'b1);
    wt(2300);
    sink_at_reg <= 8'h0f;
    hi = 8 * $urandom_range(12, 4);
    host_model_i.wave(hi, 10);
    chk(3'h5, 8'h01);
    chk(3'h6, 8'(hi / 8));
    host_model_i.set_lines(1'b0, 1'b0, 1'b0);
    wt(2500);
    chk(3'h2, 8'h00);
    end_of_test();
  end
endmodule // dimming_control_tb_top
`default_nettype wire

// ---- verif/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Host dimming lines
  output logic enable_in,
  output logic onoff_in,
  output logic analog_dim_input
);
  // ==========
  // Line control
  initial begin
    enable_in = 1'b0;
    onoff_in = 1'b0;
    analog_dim_input = 1'b0;
  end
  task automatic set_lines(input logic e, input logic o, input logic a);
    @(posedge clk);
    enable_in <= e;
    onoff_in <= o;
    analog_dim_input <= a;
  endtask
  // Phases of 130 cycles stay just above the minimum width
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      enable_in <= 1'b0;
      repeat (130) @(posedge clk);
      enable_in <= 1'b1;
      repeat (129) @(posedge clk);
    end
  endtask
  task automatic wave(input int hi, input int n);
    repeat (n) begin
      @(posedge clk);
      analog_dim_input <= 1'b1;
      repeat (hi - 1) @(posedge clk);
      analog_dim_input <= 1'b0;
      repeat (127 - hi) @(posedge clk);
    end
  endtask
endmodule // host_model
`default_nettype wire
